// file: baec_assertions.sv
// checker of the bus address error checker outputs
`timescale 1ns/100ps
`default_nettype none
module baec_chk (
   input wire logic                CLK_IN,
   input wire logic                NRST_IN,
   input wire logic                SINGLE_CHIP_IN,
   input wire baec_pkg::baec_req_t CPU_REQ_IN,
   input wire baec_pkg::baec_req_t DMA_REQ_IN,
   input wire baec_pkg::baec_req_t XFER_REQ_IN,
   input wire baec_pkg::baec_err_t ERR_OUT
);
   // ---------
   // core cycle decode; core wins arbitration so its cycles are always judged
   // ---------
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   wire logic        f = CPU_REQ_IN.valid && CPU_REQ_IN.cycle == baec_pkg::BAEC_CYC_FETCH;
   wire logic        d = CPU_REQ_IN.valid && CPU_REQ_IN.cycle != baec_pkg::BAEC_CYC_FETCH;
   wire logic [31:0] a = CPU_REQ_IN.addr;
   wire logic [1:0]  s = CPU_REQ_IN.size;
   wire logic        q = !CPU_REQ_IN.valid && DMA_REQ_IN.valid && DMA_REQ_IN.addr[0] && DMA_REQ_IN.size == 2'h1;
   wire logic        i = !(CPU_REQ_IN.valid || DMA_REQ_IN.valid || XFER_REQ_IN.valid);
   sequence s_mis;
      ERR_OUT.err && ERR_OUT.misalign;
   endsequence
   sequence s_bad;
      ERR_OUT.err && ERR_OUT.bad_space;
   endsequence
   a_fetch_odd: assert property (f && a[0] |=> s_mis) else $error("odd fetch");
   a_periph_fetch: assert property (f && (a & baec_pkg::PERIPH_MASK) == baec_pkg::PERIPH_BASE |=> s_bad)
      else $error("peripheral fetch");
   a_ext_fetch: assert property (f && SINGLE_CHIP_IN && a >= baec_pkg::EXTMEM_BASE
      && a < baec_pkg::EXTMEM_TOP |=> s_bad) else $error("external fetch");
   a_word_odd: assert property (d && s == 2'h1 && a[0] |=> s_mis) else $error("odd word");
   a_long_mis: assert property (d && s == 2'h2 && a[1:0] != 2'h0 |=> s_mis) else $error("long");
   a_dlong_mis: assert property (d && s == 2'h3 && a[2:0] != 3'h0 |=> s_mis) else $error("dlong");
   a_data_ok: assert property (d && (a[2:0] & ((3'h1 << s) - 3'h1)) == 3'h0 |=> !ERR_OUT.err)
      else $error("aligned data");
   a_dma_report: assert property (q |=> ERR_OUT.err && ERR_OUT.master == baec_pkg::BAEC_MST_DMA
      && ERR_OUT.addr == $past(DMA_REQ_IN.addr)) else $error("dma report");
   a_idle_quiet: assert property (i |=> !ERR_OUT.err) else $error("idle report");
   a_shadow_skip: assert property (d && s == 2'h0 && DMA_REQ_IN.valid |=> !ERR_OUT.err)
      else $error("shadowed cycle");
endmodule
bind baec_top baec_chk chk_u (.*);
`default_nettype wire

// file: baec_classify.sv
// combinational classifier: decides whether one bus cycle is an address error
`timescale 1ns/100ps
`default_nettype none

module baec_classify (
   input  wire baec_pkg::baec_req_t req_in,
   input  wire logic                single_chip_in,
   output logic                     misalign_out,
   output logic                     bad_space_out
);

   // ---------------------------------------------------------------
   // space decode
   // ---------------------------------------------------------------
   logic in_periph;
   logic in_extmem;

   // external space is taken as a window below a fixed top
   assign in_periph = (req_in.addr & baec_pkg::PERIPH_MASK) == baec_pkg::PERIPH_BASE;
   assign in_extmem = (req_in.addr >= baec_pkg::EXTMEM_BASE) && (req_in.addr < baec_pkg::EXTMEM_TOP);

   // ---------------------------------------------------------------
   // alignment and space checks
   // ---------------------------------------------------------------
   always_comb begin
      misalign_out  = 1'b0;
      bad_space_out = 1'b0;
      if (req_in.valid) begin
         if (req_in.cycle == baec_pkg::BAEC_CYC_FETCH) begin
            misalign_out  = req_in.addr[0];                        // RULE2
            bad_space_out = in_periph                              // RULE3
                          | (single_chip_in & in_extmem);          // RULE4
         end else begin
            // data space never faults on its own; only alignment counts
            case (req_in.size)                                     // RULE9
               baec_pkg::BAEC_SZ_BYTE:  misalign_out = 1'b0;       // RULE7
               baec_pkg::BAEC_SZ_WORD:  misalign_out = req_in.addr[0];       // RULE5
               baec_pkg::BAEC_SZ_LONG:  misalign_out = |req_in.addr[1:0];    // RULE6
               baec_pkg::BAEC_SZ_DLONG: misalign_out = |req_in.addr[2:0];    // RULE8
               default:                 misalign_out = 1'b0;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// file: baec_master_model.sv
// bus master model: presents one master's cycle
`timescale 1ns/100ps
`default_nettype none
module baec_master_model (
   input  wire logic                clk_in,
   input  wire baec_pkg::baec_req_t cmd_in,
   output var  baec_pkg::baec_req_t req_out
);
   baec_pkg::baec_req_t last_r = '0;
   // idle bus toggles each cycle so a stale cycle never looks live
   always_ff @(posedge clk_in) last_r <= req_out;
   always_comb req_out = cmd_in.valid ? cmd_in : {1'b0, ~last_r[37:0]};
endmodule
`default_nettype wire

// file: baec_pkg.sv
// package with the shared types and constants of the bus address error checker
package baec_pkg;

   // ---------------------------------------------------------------
   // address map and widths
   // ---------------------------------------------------------------
   localparam int          ADDR_W      = 32;
   localparam logic [31:0] PERIPH_BASE = 32'hFFFC_0000;  // on-chip peripheral module space
   localparam logic [31:0] PERIPH_MASK = 32'hFFFC_0000;
   localparam logic [31:0] EXTMEM_BASE = 32'h0400_0000;  // external memory space
   localparam logic [31:0] EXTMEM_MASK = 32'hE000_0000;
   localparam logic [31:0] EXTMEM_TOP  = 32'h2000_0000;

   // ---------------------------------------------------------------
   // cycle classification
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BAEC_SZ_BYTE,
      BAEC_SZ_WORD,
      BAEC_SZ_LONG,
      BAEC_SZ_DLONG
   } baec_size_t;

   typedef enum logic [1:0] {
      BAEC_MST_CPU,
      BAEC_MST_DMA,
      BAEC_MST_XFER
   } baec_master_t;

   typedef enum logic [1:0] {
      BAEC_CYC_FETCH,
      BAEC_CYC_READ,
      BAEC_CYC_WRITE
   } baec_cycle_t;

   typedef struct packed {
      logic                valid;
      baec_master_t        master;
      baec_cycle_t         cycle;
      baec_size_t          size;
      logic [ADDR_W-1:0]   addr;
   } baec_req_t;

   typedef struct packed {
      logic                err;      // one-cycle error pulse
      baec_master_t        master;
      baec_cycle_t         cycle;
      logic                misalign;
      logic                bad_space;
      logic [ADDR_W-1:0]   addr;
   } baec_err_t;

   // reset value of the error report
   localparam baec_err_t ERR_RESET = '0;

endpackage

// file: baec_top.sv
// top of the bus address error checker: arbitrated sample of each master's cycle
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1: check every fetch and data cycle (only the bus owner's cycle is checked; a shadowed lower master's cycle is not)
// RULE2: odd-address instruction fetch is an error
// RULE3: fetch from peripheral space is an error
// RULE4: single-chip mode external fetch is an error
// RULE5: odd word data access is an error
// RULE6: misaligned longword data access is an error
// RULE7: byte/word peripheral accesses raise no error (an odd-address word access still gives a misalign error)
// RULE8: misaligned double-longword access is an error
// RULE9: alignment judged from low address bits
// RULE10: report error with master and cycle type
module baec_top (
   input  wire  logic                CLK_IN,
   input  wire  logic                NRST_IN,
   input  wire  logic                SINGLE_CHIP_IN,
   input  wire  baec_pkg::baec_req_t CPU_REQ_IN,
   input  wire  baec_pkg::baec_req_t DMA_REQ_IN,
   input  wire  baec_pkg::baec_req_t XFER_REQ_IN,
   output var   baec_pkg::baec_err_t ERR_OUT
);

   // ---------------------------------------------------------------
   // timing and contract
   // ---------------------------------------------------------------
   // cycle n   : a master shows its cycle with valid high
   // edge n+1  : the verdict is registered and shown on the report
   // cycle n+1 : the report stands for this one cycle only
   // cycle n+2 : the report drops unless a new cycle faulted
   // back-to-back faulted cycles give a report in every cycle
   // nothing is refused and nothing is queued: a cycle of a lower
   // master that is shadowed by a higher one is not judged, which
   // is the price of a single report path
   // the single-chip input is a level, sampled with the cycle itself

   // ---------------------------------------------------------------
   // bus ownership
   // ---------------------------------------------------------------
   // who owns the bus in the current cycle; only one cycle is judged
   typedef enum logic [1:0] {
      BAEC_GNT_NONE,
      BAEC_GNT_CPU,
      BAEC_GNT_DMA,
      BAEC_GNT_XFER
   } baec_grant_t;

   baec_grant_t         grant;
   baec_pkg::baec_req_t cpu_req;
   baec_pkg::baec_req_t dma_req;
   baec_pkg::baec_req_t xfer_req;
   baec_pkg::baec_req_t sel_req;
   baec_pkg::baec_err_t err_r;
   baec_pkg::baec_err_t err_nxt;
   logic                cpu_mis;
   logic                cpu_space;
   logic                dma_mis;
   logic                dma_space;
   logic                xfer_mis;
   logic                xfer_space;
   logic                misalign;
   logic                bad_space;

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   // each port belongs to one master, so the port and not the incoming
   // master field says who owns the cycle; only the core fetches, so a
   // fetch code from another master is judged as a data read
   function automatic baec_pkg::baec_req_t norm_req(
      input baec_pkg::baec_req_t    req,
      input baec_pkg::baec_master_t mst
   );
      baec_pkg::baec_req_t r;
      r        = req;
      r.master = mst;
      if (mst != baec_pkg::BAEC_MST_CPU && r.cycle == baec_pkg::BAEC_CYC_FETCH) begin
         r.cycle = baec_pkg::BAEC_CYC_READ;
      end
      return r;
   endfunction

   // fixed priority: core first, then dma, then transfer controller;
   // a lower master that is shadowed is not judged in that cycle
   function automatic baec_grant_t pick_owner(
      input logic cpu_v,
      input logic dma_v,
      input logic xfer_v
   );
      baec_grant_t g;
      g = BAEC_GNT_NONE;
      if (cpu_v) begin
         g = BAEC_GNT_CPU;
      end else if (dma_v) begin
         g = BAEC_GNT_DMA;
      end else if (xfer_v) begin
         g = BAEC_GNT_XFER;
      end
      return g;
   endfunction

   // the report carries its details only while the error bit is up,
   // so a consumer that ignores the bit still never sees stale fields
   function automatic baec_pkg::baec_err_t build_report(
      input baec_pkg::baec_req_t req,
      input logic                mis,
      input logic                space
   );
      baec_pkg::baec_err_t e;
      e     = baec_pkg::ERR_RESET;
      e.err = req.valid & (mis | space);       // RULE1
      if (e.err) begin
         e.master    = req.master;             // RULE10
         e.cycle     = req.cycle;              // RULE10
         e.misalign  = mis;
         e.bad_space = space;
         e.addr      = req.addr;
      end
      return e;
   endfunction

   // ---------------------------------------------------------------
   // cycle normalisation
   // ---------------------------------------------------------------
   // the same clean-up for all three ports
   assign cpu_req  = norm_req(CPU_REQ_IN, baec_pkg::BAEC_MST_CPU);
   assign dma_req  = norm_req(DMA_REQ_IN, baec_pkg::BAEC_MST_DMA);
   assign xfer_req = norm_req(XFER_REQ_IN, baec_pkg::BAEC_MST_XFER);

   // ---------------------------------------------------------------
   // classification
   // ---------------------------------------------------------------
   // every master is judged in parallel and the verdict picked later;
   // this costs two more classifiers but keeps the priority mux off
   // the address compare path

   // core cycles, the only ones that may be fetches
   baec_classify u_classify_cpu (
      .req_in         (cpu_req),
      .single_chip_in (SINGLE_CHIP_IN),
      .misalign_out   (cpu_mis),
      .bad_space_out  (cpu_space)
   );

   // dma cycles, always data after normalisation
   baec_classify u_classify_dma (
      .req_in         (dma_req),
      .single_chip_in (SINGLE_CHIP_IN),
      .misalign_out   (dma_mis),
      .bad_space_out  (dma_space)
   );

   // transfer controller cycles, always data after normalisation
   baec_classify u_classify_xfer (
      .req_in         (xfer_req),
      .single_chip_in (SINGLE_CHIP_IN),
      .misalign_out   (xfer_mis),
      .bad_space_out  (xfer_space)
   );

   // ---------------------------------------------------------------
   // cycle selection
   // ---------------------------------------------------------------
   // the owner's cycle and verdict go on; an idle bus gives an
   // all-zero cycle with valid low, which is never reported
   always_comb begin
      grant     = pick_owner(cpu_req.valid, dma_req.valid, xfer_req.valid);
      sel_req   = '0;
      misalign  = 1'b0;
      bad_space = 1'b0;
      case (grant)
         BAEC_GNT_CPU: begin
            sel_req   = cpu_req;
            misalign  = cpu_mis;
            bad_space = cpu_space;
         end
         BAEC_GNT_DMA: begin
            sel_req   = dma_req;
            misalign  = dma_mis;
            bad_space = dma_space;
         end
         BAEC_GNT_XFER: begin
            sel_req   = xfer_req;
            misalign  = xfer_mis;
            bad_space = xfer_space;
         end
         default: begin
            sel_req   = '0;
            misalign  = 1'b0;
            bad_space = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // error report
   // ---------------------------------------------------------------
   // only the bus owner's valid cycle is judged, a shadowed one is not; report is a one-cycle pulse
   always_comb begin
      err_nxt = build_report(sel_req, misalign, bad_space);   // RULE1 RULE10
   end

   // registered so the exception logic sees a clean, glitch-free record
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         err_r <= baec_pkg::ERR_RESET;
      end else begin
         err_r <= err_nxt;
      end
   end

   assign ERR_OUT = err_r;

endmodule

`default_nettype wire

// file: baec_top_tb_top.sv
// testbench of the bus address error checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin err_count++; \
   $display("wrong value at %0t got %h exp %h", $time, (g), (x)); end end
module baec_top_tb_top;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                sc = 1'b0;
   baec_pkg::baec_req_t cmd [3] = '{default: '0};
   baec_pkg::baec_req_t req [3];
   baec_pkg::baec_err_t err;
   int                  err_count = 0;
   int                  n_tests = 0;
   initial forever #10 clk = ~clk;
   for (genvar i = 0; i < 3; i++) begin : g_m
      baec_master_model mst_u (.clk_in(clk), .cmd_in(cmd[i]), .req_out(req[i]));
   end
   baec_top dut_u (.CLK_IN(clk), .NRST_IN(nrst), .SINGLE_CHIP_IN(sc), .CPU_REQ_IN(req[0]),
      .DMA_REQ_IN(req[1]), .XFER_REQ_IN(req[2]), .ERR_OUT(err));
   // one cycle, then an idle cycle so the one-cycle report is seen to drop
   task automatic go(input int m, input int cy, input int sz, input logic [31:0] a, input logic [2:0] e);
      cmd[m] = '{1'b1, baec_pkg::baec_master_t'(m), baec_pkg::baec_cycle_t'(cy), baec_pkg::baec_size_t'(sz), a};
      @(negedge clk);
      `CHK({err.err, err.misalign, err.bad_space}, e)
      `CHK({err.master, err.cycle, err.addr}, e[2] ? {m[1:0], cy[1:0], a} : 36'h0)
      cmd[m].valid = 1'b0;
      @(negedge clk);
      `CHK(err.err, 1'b0)
   endtask
   task automatic t_fetch;
      go(0, 0, 1, 32'h0000_1000, 3'h0);
      go(0, 0, 1, 32'h0000_1001, 3'h6);
      go(0, 0, 1, 32'hFFFC_0010, 3'h5);
      sc = 1'b1;
      go(0, 0, 1, 32'h1FFF_FFFE, 3'h5);
      go(0, 0, 1, 32'h2000_0000, 3'h0);
      sc = 1'b0;
      go(0, 0, 1, 32'h0400_0000, 3'h0);
      $display("fetch test done");
   endtask
   task automatic t_data;
      logic x;
      for (int m = 0; m < 3; m++) begin
         for (int s = 0; s < 4; s++) begin
            for (int o = 0; o < 8; o++) begin
               x = |(o[2:0] & ((3'h1 << s) - 3'h1));
               go(m, 1 + o % 2, s, 32'h0000_2000 + o, {x, x, 1'b0});
            end
         end
      end
      go(0, 1, 0, 32'hFFFC_0001, 3'h0);
      go(0, 2, 1, 32'hFFFC_0002, 3'h0);
      $display("data test done");
   endtask
   // two masters at once: only the owner is judged; a non-core fetch counts as a read
   task automatic t_arb;
      cmd[1] = '{1'b1, baec_pkg::BAEC_MST_DMA, baec_pkg::BAEC_CYC_FETCH, baec_pkg::BAEC_SZ_WORD, 32'h0000_3001};
      @(negedge clk);
      `CHK({err.err, err.misalign, err.bad_space, err.master, err.cycle}, 7'h65)
      cmd[0] = '{1'b1, baec_pkg::BAEC_MST_CPU, baec_pkg::BAEC_CYC_READ, baec_pkg::BAEC_SZ_BYTE, 32'h0000_3000};
      @(negedge clk);
      `CHK(err.err, 1'b0)
      cmd[0].valid = 1'b0;
      cmd[1].valid = 1'b0;
      @(negedge clk);
      `CHK(err.err, 1'b0)
      $display("arbitration test done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      t_fetch;
      t_data;
      t_arb;
      final_report;
   end
   // watchdog: about twenty times the expected run
   initial begin
      #90000;
      err_count++;
      final_report;
   end
endmodule
`default_nettype wire
